// >>> logic/frame_shifter.sv
// Serial-clock side: shifts one frame in and hands the completed word over
`timescale 1ns/1ps
`include "serial_dac_map.svh"
module frame_shifter (
   input  wire logic  i_serial_clock,
   input  wire logic  i_frame_n,
   input  wire logic  i_serial_data,
   word_link_if.link  lnk
);
   import serial_dac_pkg::*;

   logic [`BIT_COUNT_W-1:0] count_q = `BIT_COUNT_ZERO;
   logic [`WORD_WIDTH-2:0]  shift_q;
   frame_word_type          word_q;
   // Power-up value: the serial clock has no reset of its own
   logic                    toggle_q = 1'b0;

   wire last_bit = (count_q == `BIT_COUNT_LAST);
   wire shifting = (count_q != `BIT_COUNT_DONE);

   always_ff @(negedge i_serial_clock or posedge i_frame_n) begin
      if (i_frame_n) begin
         count_q <= `BIT_COUNT_ZERO;
      end else if (shifting) begin
         count_q <= count_q + 1'b1;
      end
   end

   always_ff @(negedge i_serial_clock) begin
      if (!i_frame_n && shifting) begin
         shift_q <= {shift_q[`WORD_WIDTH-3:0], i_serial_data};
      end
   end

   always_ff @(negedge i_serial_clock) begin
      if (!i_frame_n && last_bit) begin
         word_q   <= {shift_q, i_serial_data};
         toggle_q <= !toggle_q;
      end
   end

   assign lnk.word        = word_q;
   assign lnk.done_toggle = toggle_q;
endmodule // frame_shifter

// >>> logic/serial_dac_input_frame.sv
// Serial input frame logic of a 10-bit voltage-output converter
//
// Contract
// - Each of the first sixteen falling serial clock edges inside a frame shifts the data pin in; later edges are ignored.
// - The shift register works only while frame select is low, and the host lowers it first.
// - The sixteenth falling edge of a frame moves the word toward the converter register.
// - Frame select rising before the sixteenth edge discards the frame, leaving the code alone.
// - From reset the output is zero until the first complete frame has been applied.
// - The converter register holds a 10-bit unsigned code taken from the received word.
// - A power-down state is selected through the word and stops driving the output.
// - All ones gives full scale and all zeros gives zero output.
`timescale 1ns/1ps
`include "serial_dac_map.svh"
module serial_dac_input_frame (
   input  wire logic                      i_clock,
   input  wire logic                      i_resetn,
   input  wire logic                      i_serial_clock,
   input  wire logic                      i_frame_n,
   input  wire logic                      i_serial_data,
   input  wire logic                      i_hold_update,
   output serial_dac_pkg::code_type       o_analog_output,
   output serial_dac_pkg::power_mode_type o_power_mode,
   output logic                           o_powered_down,
   output logic                           o_output_valid,
   output logic                           o_full_scale,
   output logic                           o_update,
   output logic                           o_word_ready,
   output logic                           o_word_dropped,
   output logic                           o_frame_abort
);
   import serial_dac_pkg::*;

   // ==========================================================
   // Link side
   // ==========================================================
   word_link_if lnk ();

   frame_shifter u_shifter (
      .i_serial_clock (i_serial_clock),
      .i_frame_n      (i_frame_n),
      .i_serial_data  (i_serial_data),
      .lnk            (lnk.link)
   );

   // ==========================================================
   // Synchronisers
   // ==========================================================
   // Toggle, frame select and hold pin all come from outside i_clock
   wire  [`SYNC_COUNT-1:0] sync_in;
   wire  [`SYNC_COUNT-1:0] sync_out;

   assign sync_in[`SYNC_TOGGLE] = lnk.done_toggle;
   assign sync_in[`SYNC_FRAME]  = i_frame_n;
   assign sync_in[`SYNC_HOLD]   = i_hold_update;

   // Reset levels match the idle frame pin; the hold pin blocks the
   // drain for two cycles after reset, which costs nothing.
   genvar g;
   generate
      for (g = 0; g < `SYNC_COUNT; g++) begin : g_sync
         logic meta_q;
         logic sync_q;

         always_ff @(posedge i_clock) begin
            if (!i_resetn) begin
               meta_q <= 1'b1;
               sync_q <= 1'b1;
            end else begin
               meta_q <= sync_in[g];
               sync_q <= meta_q;
            end
         end

         assign sync_out[g] = sync_q;
      end
   endgenerate

   wire toggle_sync = sync_out[`SYNC_TOGGLE];
   wire frame_sync  = sync_out[`SYNC_FRAME];
   wire hold_sync   = sync_out[`SYNC_HOLD];

   // ==========================================================
   // Word arrival
   // ==========================================================
   logic                 toggle_seen_q;
   logic [`SEED_W-1:0]   seed_q;
   logic                 frame_last_q;

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         toggle_seen_q <= 1'b0;
         frame_last_q  <= 1'b1;
      end else begin
         toggle_seen_q <= toggle_sync;
         frame_last_q  <= frame_sync;
      end
   end

   // ==========================================================
   // Arrival reference
   // ==========================================================
   // The toggle keeps its value across a reset of this side, while the
   // synchronisers restart from a fixed level. The reference is trusted
   // only once the toggle has passed both flip-flops and been copied;
   // otherwise a reset in mid-run would look like a finished word.
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         seed_q <= '0;
      end else if (seed_q != `SEED_DONE) begin
         seed_q <= seed_q + 1'b1;
      end
   end

   wire seeded = (seed_q == `SEED_DONE);

   wire word_arrived = seeded && (toggle_sync != toggle_seen_q);
   wire frame_fell   = frame_last_q && !frame_sync;
   wire frame_rose   = !frame_last_q && frame_sync;

   // The link word stays still for a whole frame after the toggle, so
   // it is safe to read here once the toggle has crossed.
   frame_word_type fifo_wr_data;
   frame_word_type fifo_rd_data;
   logic           fifo_wr_ready;
   logic           fifo_rd_valid;
   wire            fifo_rd_ready;

   assign fifo_wr_data = lnk.core.word;

   // ==========================================================
   // Word buffer
   // ==========================================================
   word_fifo #(
      .WIDTH (`WORD_WIDTH),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .i_clock    (i_clock),
      .i_resetn   (i_resetn),
      .i_wr_valid (word_arrived),
      .o_wr_ready (fifo_wr_ready),
      .i_wr_data  (fifo_wr_data),
      .o_rd_valid (fifo_rd_valid),
      .i_rd_ready (fifo_rd_ready),
      .o_rd_data  (fifo_rd_data)
   );

   // The serial link cannot be stalled, so a word that meets a full
   // buffer is lost and reported.
   logic dropped_q;

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         dropped_q <= 1'b0;
      end else begin
         dropped_q <= word_arrived && !fifo_wr_ready;
      end
   end

   // ==========================================================
   // Abort detection
   // ==========================================================
   // The completion toggle and frame select cross separately, so the
   // decision waits a few cycles after the rise to let the toggle land.
   logic       got_word_q;
   logic [1:0] abort_wait_q;
   logic       abort_q;

   // A frame with no clock edges at all is reported as an abort too.
   wire abort_check = (abort_wait_q == `ABORT_CHECK);

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         got_word_q <= 1'b0;
      end else if (word_arrived) begin
         // An arrival in the clearing cycle still counts
         got_word_q <= 1'b1;
      end else if (frame_fell) begin
         got_word_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         abort_wait_q <= `ABORT_IDLE;
      end else if (frame_rose) begin
         abort_wait_q <= `ABORT_WAIT;
      end else if (abort_wait_q != `ABORT_IDLE) begin
         abort_wait_q <= abort_wait_q - 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         abort_q <= 1'b0;
      end else begin
         abort_q <= abort_check && !got_word_q && !word_arrived;
      end
   end

   // ==========================================================
   // Drain and update sequencer
   // ==========================================================
   drain_state_type        state_q;
   drain_state_type        state_d;
   logic [`SETTLE_W-1:0]   settle_q;
   frame_word_type         staged_q;

   localparam logic [`SETTLE_W-1:0] SETTLE_LOAD = `SETTLE_W'(`SETTLE_CYCLES);

   // Hold pin stalls the drain so the buffer fills behind it
   wire can_pop     = fifo_rd_valid && !hold_sync;
   wire settle_done = (settle_q == '0);

   assign fifo_rd_ready = (state_q == ST_IDLE) && can_pop;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (can_pop) begin
               state_d = ST_LOAD;
            end
         end
         ST_LOAD: begin
            state_d = ST_SETTLE;
         end
         ST_SETTLE: begin
            if (settle_done) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         staged_q <= '0;
      end else if (fifo_rd_ready) begin
         staged_q <= fifo_rd_data;
      end
   end

   // Gap between updates lets the output settle before the next code
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         settle_q <= '0;
      end else if (state_q == ST_LOAD) begin
         settle_q <= SETTLE_LOAD;
      end else if (!settle_done) begin
         settle_q <= settle_q - 1'b1;
      end
   end

   // ==========================================================
   // Converter register
   // ==========================================================
   code_type       code_q;
   power_mode_type mode_q;
   logic           written_q;
   logic           update_q;

   code_type       staged_code;
   power_mode_type staged_mode;

   wire      load_now    = (state_q == ST_LOAD);
   assign staged_code = staged_q[`CODE_MSB:`CODE_LSB];
   assign staged_mode = power_mode_type'(staged_q[`MODE_MSB:`MODE_LSB]);

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         code_q    <= `CODE_ZERO;
         mode_q    <= PM_NORMAL;
         written_q <= 1'b0;
      end else if (load_now) begin
         code_q    <= staged_code;
         mode_q    <= staged_mode;
         written_q <= 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         update_q <= 1'b0;
      end else begin
         update_q <= load_now;
      end
   end

   // ==========================================================
   // Output stage
   // ==========================================================
   // The update pulse leads the new output code by one cycle, because
   // the output stage adds a register after the converter register.
   code_type out_q;
   code_type out_d;
   logic     down_q;
   logic     full_q;

   wire      down_d = (mode_q != PM_NORMAL);
   assign out_d = (down_d || !written_q) ? `CODE_ZERO : code_q;

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         out_q  <= `CODE_ZERO;
         down_q <= 1'b0;
         full_q <= 1'b0;
      end else begin
         out_q  <= out_d;
         down_q <= down_d;
         full_q <= (out_d == `CODE_FULL);
      end
   end

   assign o_analog_output = out_q;
   assign o_power_mode    = mode_q;
   assign o_powered_down  = down_q;
   assign o_output_valid  = written_q;
   assign o_full_scale    = full_q;
   assign o_update        = update_q;
   assign o_word_ready    = fifo_wr_ready;
   assign o_word_dropped  = dropped_q;
   assign o_frame_abort   = abort_q;
endmodule // serial_dac_input_frame

// >>> logic/serial_dac_map.svh
// Constant map for the serial converter input frame logic
`ifndef SERIAL_DAC_MAP_SVH
`define SERIAL_DAC_MAP_SVH
`define WORD_WIDTH      16
`define CODE_WIDTH      10
`define CODE_MSB        11
`define CODE_LSB        2
`define MODE_MSB        13
`define MODE_LSB        12
`define BIT_COUNT_W     5
`define BIT_COUNT_ZERO  5'h00
`define BIT_COUNT_LAST  5'h0f
`define BIT_COUNT_DONE  5'h10
`define CODE_ZERO       10'h000
`define CODE_FULL       10'h3ff
`define FIFO_DEPTH      16
`define CLOCK_PERIOD_NS 40
`define SETTLE_TIME_NS  1000
`define SETTLE_CYCLES   ((`SETTLE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SETTLE_W        6
`define ABORT_WAIT      2'h3
`define ABORT_CHECK     2'h1
`define ABORT_IDLE      2'h0
`define SEED_W          2
`define SEED_DONE       2'h3
`define SYNC_COUNT      3
`define SYNC_TOGGLE     0
`define SYNC_FRAME      1
`define SYNC_HOLD       2
`endif

// >>> logic/serial_dac_pkg.sv
// Types shared by the serial converter input frame logic
package serial_dac_pkg;
`include "serial_dac_map.svh"
   typedef logic [`WORD_WIDTH-1:0] frame_word_type;
   typedef logic [`CODE_WIDTH-1:0] code_type;
   typedef enum logic [1:0] {
      PM_NORMAL    = 2'b00,
      PM_DOWN_LOW  = 2'b01,
      PM_DOWN_HIGH = 2'b10,
      PM_DOWN_OPEN = 2'b11
   } power_mode_type;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_LOAD   = 2'b01,
      ST_SETTLE = 2'b10
   } drain_state_type;
endpackage

// >>> logic/word_fifo.sv
// Word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             i_clock,
   input  wire logic             i_resetn,
   input  wire logic             i_wr_valid,
   output logic                  o_wr_ready,
   input  wire logic [WIDTH-1:0] i_wr_data,
   output logic                  o_rd_valid,
   input  wire logic             i_rd_ready,
   output logic [WIDTH-1:0]      o_rd_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      level_q;
   wire              push = i_wr_valid && o_wr_ready;
   wire              pop  = o_rd_valid && i_rd_ready;

   assign o_wr_ready = (level_q != FULL_LEVEL);
   assign o_rd_valid = (level_q != '0);
   assign o_rd_data  = mem_q[rd_ptr_q];

   always_ff @(posedge i_clock) begin
      if (push) begin
         mem_q[wr_ptr_q] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         level_q  <= '0;
      end else begin
         wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
         rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
         level_q  <= level_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // word_fifo

// >>> logic/word_link_if.sv
// Completed frame word and its event toggle, from the link side to the core
`timescale 1ns/1ps
interface word_link_if;
   import serial_dac_pkg::*;
   frame_word_type word;
   logic           done_toggle;
   modport link (output word, output done_toggle);
   modport core (input word, input done_toggle);
endinterface

// >>> tb/serial_dac_input_frame_sva.sv
// Assertion checker for the serial converter input frame logic
`timescale 1ns/1ps
module serial_dac_input_frame_sva (
   input wire logic                           i_clock,
   input wire logic                           i_resetn,
   input wire serial_dac_pkg::code_type       o_analog_output,
   input wire serial_dac_pkg::power_mode_type o_power_mode,
   input wire logic                           o_powered_down,
   input wire logic                           o_output_valid,
   input wire logic                           o_full_scale,
   input wire logic                           o_update,
   input wire logic                           o_word_ready,
   input wire logic                           o_word_dropped
);
   import serial_dac_pkg::*;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   update_only_a: assert property ($changed(o_analog_output) |-> o_update || $past(o_update))
      else $error("output changed without an update");
   update_pulse_a: assert property (o_update |=> !o_update)
      else $error("update pulse longer than one cycle");
   zero_start_a: assert property (!o_output_valid |-> o_analog_output == 10'h000)
      else $error("output not zero before first load");
   valid_sticky_a: assert property (o_output_valid |=> o_output_valid)
      else $error("valid flag dropped");
   valid_load_a: assert property (o_update |-> o_output_valid)
      else $error("update without valid flag");
   full_scale_a: assert property (o_full_scale == (o_analog_output == 10'h3ff))
      else $error("full scale flag wrong");
   down_zero_a: assert property (o_powered_down && $stable(o_power_mode) |-> o_analog_output == 10'h000)
      else $error("output driven in power-down");
   down_flag_a: assert property ($changed(o_power_mode) |=> o_powered_down == (o_power_mode != PM_NORMAL))
      else $error("power-down flag wrong");
   drop_full_a: assert property (o_word_dropped |-> !$past(o_word_ready))
      else $error("word dropped while buffer had room");

   cover property (o_update && o_full_scale);
   cover property (o_word_dropped);
   cover property (o_update && o_powered_down);
endmodule // serial_dac_input_frame_sva

// >>> tb/serial_dac_input_frame_tb.sv
// Self-checking testbench for the serial converter input frame logic
`timescale 1ns/1ps
module serial_dac_input_frame_tb;
   import serial_dac_pkg::*;
   logic           i_clock = 1'b0;
   logic           i_resetn;
   logic           i_hold_update = 1'b0;
   wire logic      sclk;
   wire logic      frame_n;
   wire logic      sdata;
   code_type       o_analog_output;
   power_mode_type o_power_mode;
   logic           o_powered_down, o_output_valid, o_full_scale, o_update;
   logic           o_word_ready, o_word_dropped, o_frame_abort;
   int             err_count = 0, checks_done = 0, n_upd = 0, n_abort = 0, n_drop = 0;

   always #20 i_clock = ~i_clock;

   serial_host_model serial_host_model_i (.o_serial_clock(sclk), .o_frame_n(frame_n),
      .o_serial_data(sdata));
   serial_dac_input_frame serial_dac_input_frame_i (.i_clock(i_clock), .i_resetn(i_resetn),
      .i_serial_clock(sclk), .i_frame_n(frame_n), .i_serial_data(sdata),
      .i_hold_update(i_hold_update), .o_analog_output(o_analog_output),
      .o_power_mode(o_power_mode), .o_powered_down(o_powered_down),
      .o_output_valid(o_output_valid), .o_full_scale(o_full_scale), .o_update(o_update),
      .o_word_ready(o_word_ready), .o_word_dropped(o_word_dropped),
      .o_frame_abort(o_frame_abort));

   // One-cycle pulses are counted at the falling edge, where they have settled
   always @(negedge i_clock) begin
      if (o_update === 1'b1) n_upd++;
      if (o_frame_abort === 1'b1) n_abort++;
      if (o_word_dropped === 1'b1) n_drop++;
   end

   // =====================================
   // Helpers
   function automatic logic [19:0] mk(input logic [1:0] m, input logic [9:0] c);
      return {2'b00, m, c, 2'b00, 4'h0};
   endfunction
   task check_val(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task check_flag(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task summarize;
      $display("mismatches %0d of %0d checks", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task wait_upd(input int n);
      for (int k = 0; k < 2000 && n_upd < n; k++) @(negedge i_clock);
      repeat (3) @(negedge i_clock);
      check_val(16'(n_upd), 16'(n));
   endtask
   task write_code(input logic [1:0] m, input logic [9:0] c);
      int base;
      base = n_upd;
      serial_host_model_i.shift(mk(m, c), 16);
      wait_upd(base + 1);
   endtask

   // =====================================
   // Scenarios
   task t_reset;
      i_resetn = 1'b0;
      repeat (12) @(negedge i_clock);
      i_resetn = 1'b1;
      repeat (6) @(negedge i_clock);
      check_val(o_analog_output, 16'h0000);
      check_flag(o_output_valid, 1'b0);
      check_flag(o_word_ready, 1'b1);
   endtask
   task t_abort_first;
      serial_host_model_i.shift(mk(2'b00, 10'h155), 10);
      serial_host_model_i.shift(mk(2'b00, 10'h155), 0);
      repeat (20) @(negedge i_clock);
      check_val(16'(n_abort), 16'h0002);
      check_val(16'(n_upd), 16'h0000);
      check_val(o_analog_output, 16'h0000);
   endtask
   task t_codes;
      logic [9:0] tbl [4] = '{10'h3ff, 10'h000, 10'h2aa, 10'h155};
      foreach (tbl[k]) begin
         write_code(2'b00, tbl[k]);
         check_val(o_analog_output, 16'(tbl[k]));
         check_flag(o_full_scale, tbl[k] == 10'h3ff);
      end
   endtask
   task t_long_then_abort;
      int base;
      base = n_upd;
      serial_host_model_i.shift(mk(2'b00, 10'h0f0) | 20'h0000f, 20);
      wait_upd(base + 1);
      check_val(o_analog_output, 16'h00f0);
      serial_host_model_i.shift(mk(2'b00, 10'h3ff), 15);
      repeat (20) @(negedge i_clock);
      check_val(16'(n_abort), 16'h0003);
      check_val(o_analog_output, 16'h00f0);
   endtask
   task t_power;
      for (int m = 1; m < 4; m++) begin
         write_code(2'(m), 10'h2aa);
         check_val(o_analog_output, 16'h0000);
         check_val(o_power_mode, 16'(m));
         check_flag(o_powered_down, 1'b1);
      end
      write_code(2'b00, 10'h2aa);
      check_val(o_analog_output, 16'h02aa);
      check_flag(o_powered_down, 1'b0);
   endtask
   task t_fifo;
      int base;
      i_hold_update = 1'b1;
      repeat (3) @(negedge i_clock);
      base = n_upd;
      for (int k = 1; k <= 17; k++) serial_host_model_i.shift(mk(2'b00, 10'(k)), 16);
      repeat (8) @(negedge i_clock);
      check_flag(o_word_ready, 1'b0);
      check_val(16'(n_drop), 16'h0001);
      check_val(16'(n_upd - base), 16'h0000);
      i_hold_update = 1'b0;
      wait_upd(base + 16);
      check_val(o_analog_output, 16'h0010);
      check_flag(o_word_ready, 1'b1);
   endtask

   // Limit covers about eight times the expected run
   initial begin
      #500us;
      err_count++;
      summarize();
   end

   initial begin
      t_reset();
      t_abort_first();
      t_codes();
      t_long_then_abort();
      t_power();
      t_fifo();
      // Second reset in mid-run, then one fresh write
      t_reset();
      write_code(2'b00, 10'h155);
      check_val(o_analog_output, 16'h0155);
      summarize();
   end
endmodule // serial_dac_input_frame_tb

bind serial_dac_input_frame serial_dac_input_frame_sva serial_dac_input_frame_sva_i (
   .i_clock(i_clock), .i_resetn(i_resetn), .o_analog_output(o_analog_output),
   .o_power_mode(o_power_mode), .o_powered_down(o_powered_down),
   .o_output_valid(o_output_valid), .o_full_scale(o_full_scale), .o_update(o_update),
   .o_word_ready(o_word_ready), .o_word_dropped(o_word_dropped));

// >>> tb/serial_host_model.sv
// Behavioural serial host that writes frames into the converter link
`timescale 1ns/1ps
module serial_host_model (
   output logic o_serial_clock,
   output logic o_frame_n,
   output logic o_serial_data
);
   localparam int HALF_NS = 32;

   // Clock idles high and stands still between frames
   initial begin
      o_serial_clock = 1'b1;
      o_frame_n      = 1'b1;
      o_serial_data  = 1'b0;
   end

   // Sends the top n bits of v, then closes the frame
   task automatic shift(input logic [19:0] v, input int n);
      o_frame_n = 1'b0;
      #(HALF_NS);
      for (int k = 0; k < n; k++) begin
         o_serial_data = v[19-k];
         #(HALF_NS);
         // 64 ns period stays below the limit
         o_serial_clock = 1'b0;
         #(HALF_NS);
         o_serial_clock = 1'b1;
      end
      #(HALF_NS);
      o_frame_n     = 1'b1;
      // Released line shows the inverse, never a stale value
      o_serial_data = ~o_serial_data;
      #(8 * HALF_NS);
   endtask
endmodule // serial_host_model
